// ==== dms_map.vh ====
// Constants for the front-panel display mode sequencer
`ifndef DMS_MAP_VH
`define DMS_MAP_VH

// ----------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------
`define DMS_CLK_HZ 100000000
`define DMS_CYC_PER_MS (`DMS_CLK_HZ / 1000)
`define DMS_DEBOUNCE_MS 10
`define DMS_LONG_PRESS_MS 1000
`define DMS_DWELL_MS 1000
`define DMS_VIEW_DELAY_MS 200
`define DMS_DIAGNOSTIC_VIEW_DELAY_MS 600
`define DMS_BLINK_MS 250

// ----------------------------------------------------------------------
// Top-level views, one-hot
// ----------------------------------------------------------------------
`define DMS_V_LOCAL 3'h1
`define DMS_V_REMOTE 3'h2
`define DMS_V_DIAGNOSTIC_VIEW 3'h4

// ----------------------------------------------------------------------
// Diagnostic sub-views, one-hot
// ----------------------------------------------------------------------
`define DMS_S_TEMP 4'h1
`define DMS_S_SUPPLY 4'h2
`define DMS_S_FW 4'h4
`define DMS_S_ERR 4'h8

// ----------------------------------------------------------------------
// Phases of each readout sequence
// ----------------------------------------------------------------------
`define DMS_PH_ZERO 2'h0
`define DMS_PH_ONE 2'h1
`define DMS_PH_TWO 2'h2
`define DMS_PH_LAST4 2'h3

// ----------------------------------------------------------------------
// Character codes and four-character texts (ASCII)
// ----------------------------------------------------------------------
`define DMS_CH_SPACE 8'h20
`define DMS_CH_MINUS 8'h2D
`define DMS_CH_ZERO 8'h30
`define DMS_CH_ALPHA 8'h37
`define DMS_CH_C 8'h43
`define DMS_TXT_LINK 32'h204F_5054
`define DMS_TXT_FAR 32'h434F_5054
`define DMS_TXT_TEMP 32'h5445_4D50
`define DMS_TXT_SUPPLY 32'h504F_5752
`define DMS_TXT_FW 32'h5245_5620
`define DMS_TXT_ERR 32'h4341_4D20
`define DMS_TXT_OK 32'h2020_4F4B
`define DMS_TXT_FAIL 32'h4641_494C
`define DMS_BOARD_TAGS 128'h4348_4152_4449_5350_4241_5345_5053_2020

`endif

// ==== dms_debounce.v ====
// Selector button synchroniser, debouncer and press classifier
`timescale 1ns/1ps
`include "dms_map.vh"

module dms_debounce #(
   parameter DEBOUNCE_CYC = `DMS_DEBOUNCE_MS * `DMS_CYC_PER_MS,
   parameter LONG_CYC = `DMS_LONG_PRESS_MS * `DMS_CYC_PER_MS
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Raw button, high while pressed
   input wire btn_raw,
   // Press events
   output reg short_press,
   output reg long_press
);

   reg sync_a; // First synchroniser stage
   reg sync_b; // Second synchroniser stage
   reg stable; // Debounced level
   reg [31:0] bounce_cnt; // Time the raw level has differed from stable
   reg [31:0] hold_cnt; // Time the debounced press has lasted
   reg long_sent; // Long event already issued for this press

   // ----------------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= btn_raw;
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------------------------------------
   // Debounce and classify: one event per physical press
   // ----------------------------------------------------------------------
   // A press shorter than LONG_CYC gives one short event at release; a
   // longer one gives one long event when the threshold is reached and
   // nothing at release, so a press never counts twice.
   always @(posedge core_clk) begin
      if (srst) begin
         stable <= 1'b0;
         bounce_cnt <= 32'h0000_0000;
         hold_cnt <= 32'h0000_0000;
         long_sent <= 1'b0;
         short_press <= 1'b0;
         long_press <= 1'b0;
      end else begin
         short_press <= 1'b0;
         long_press <= 1'b0;
         // Level must hold DEBOUNCE_CYC cycles before it is believed
         if (sync_b == stable) begin
            bounce_cnt <= 32'h0000_0000;
         end else if (bounce_cnt >= DEBOUNCE_CYC - 1) begin
            bounce_cnt <= 32'h0000_0000;
            stable <= sync_b;
            if (!sync_b && !long_sent) begin
               short_press <= 1'b1;
            end
            hold_cnt <= 32'h0000_0000;
            long_sent <= 1'b0;
         end else begin
            bounce_cnt <= bounce_cnt + 32'h0000_0001;
         end
         // Measure the hold time of a press
         if (stable && !long_sent && (sync_b == stable)) begin
            if (hold_cnt >= LONG_CYC - 1) begin
               long_press <= 1'b1;
               long_sent <= 1'b1;
            end else begin
               hold_cnt <= hold_cnt + 32'h0000_0001;
            end
         end
      end
   end

endmodule // dms_debounce

// ==== dms_display_mode_sequencer.v ====
// Front-panel readout sequencer: views, sub-views, text and colour
`timescale 1ns/1ps
`include "dms_map.vh"

module dms_display_mode_sequencer #(
   parameter NUM_BOARDS = 4,
   parameter BW = 2,
   parameter [NUM_BOARDS*32-1:0] BOARD_TAGS = `DMS_BOARD_TAGS,
   parameter DEBOUNCE_CYC = `DMS_DEBOUNCE_MS * `DMS_CYC_PER_MS,
   parameter LONG_CYC = `DMS_LONG_PRESS_MS * `DMS_CYC_PER_MS,
   parameter DWELL_CYC = `DMS_DWELL_MS * `DMS_CYC_PER_MS,
   parameter VIEW_DELAY_CYC = `DMS_VIEW_DELAY_MS * `DMS_CYC_PER_MS,
   parameter DIAGNOSTIC_VIEW_DELAY_CYC = `DMS_DIAGNOSTIC_VIEW_DELAY_MS * `DMS_CYC_PER_MS,
   parameter BLINK_CYC = `DMS_BLINK_MS * `DMS_CYC_PER_MS
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Operator selector button, high while pressed
   input wire select_btn,
   // Receive strength sources, signed dBm
   input wire [7:0] local_rx_dbm,
   input wire [7:0] remote_rx_dbm,
   // Per-board status, board k in slice k
   input wire [NUM_BOARDS*8-1:0] board_temp_c,
   input wire [NUM_BOARDS-1:0] board_temp_ok,
   input wire [NUM_BOARDS-1:0] board_supply_ok,
   input wire [NUM_BOARDS-1:0] board_has_mcu,
   input wire [NUM_BOARDS*16-1:0] board_fw_version,
   // Far unit error status
   input wire [15:0] far_error,
   // Four-character display, leftmost in bits 31:24
   output reg [31:0] disp_text,
   output reg disp_green,
   output reg disp_red,
   // View indicator LEDs
   output wire led_local,
   output wire led_remote,
   output wire led_diagnostic_view
);

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   // One digit to its character, hex letters included
   function [7:0] dig;
      input [3:0] d;
      begin
         dig = (d < 4'h a) ? `DMS_CH_ZERO + {4'h0, d} : `DMS_CH_ALPHA + {4'h0, d};
      end
   endfunction

   // Signed value to text: sign then up to three digits, right-aligned with leading spaces, or two digits and C
   function [31:0] fmt_num;
      input [7:0] v;
      input with_c;
      reg [7:0] mag;
      reg [7:0] h;
      reg [7:0] t;
      reg [7:0] o;
      reg [7:0] sg;
      begin
         mag = v[7] ? (8'h00 - v) : v;
         h = mag / 8'h64;
         t = (mag / 8'h0a) % 8'h0a;
         o = mag % 8'h0a;
         sg = v[7] ? `DMS_CH_MINUS : `DMS_CH_SPACE;
         if (with_c) begin
            fmt_num = {sg, dig(t[3:0]), dig(o[3:0]), `DMS_CH_C};
         end else if (h != 8'h00) begin
            fmt_num = {sg, dig(h[3:0]), dig(t[3:0]), dig(o[3:0])};
         end else if (t != 8'h00) begin
            fmt_num = {`DMS_CH_SPACE, sg, dig(t[3:0]), dig(o[3:0])};
         end else begin
            fmt_num = {`DMS_CH_SPACE, `DMS_CH_SPACE, sg, dig(o[3:0])};
         end
      end
   endfunction

   // Next board index, wrapping at the last board
   function [BW-1:0] next_board;
      input [BW-1:0] b;
      begin
         next_board = (b == NUM_BOARDS - 1) ? {BW{1'b0}} : b + 1'b1;
      end
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   wire short_press; // Quick press event
   wire long_press; // Held press event
   wire any_press = short_press | long_press;
   reg [2:0] view; // Active view, one-hot
   reg [2:0] pend_view; // View waiting for the switch delay
   reg switching; // Switch delay running
   reg [31:0] sw_cnt; // Switch delay counter
   reg [3:0] sub; // Diagnostic sub-view, one-hot
   reg [1:0] phase; // Item within the readout sequence
   reg [BW-1:0] board; // Board being reported
   reg far_tag_done; // Far tag shown once in the remote view
   reg [31:0] dwell_cnt; // Item dwell divider
   reg blinking; // Diagnostic LED blinks after entry
   reg [31:0] blink_cnt; // Blink rate divider
   reg blink_on; // Blink phase
   wire dwell_tick = (dwell_cnt >= DWELL_CYC - 1);
   wire in_diagnostic_view = (view == `DMS_V_DIAGNOSTIC_VIEW);
   wire fw_skip = (sub == `DMS_S_FW) && !board_has_mcu[board] && (|board_has_mcu);
   wire [2:0] next_view = (view == `DMS_V_DIAGNOSTIC_VIEW) ? `DMS_V_LOCAL : {view[1:0], 1'b0};

   // ----------------------------------------------------------------------
   // Button front end
   // ----------------------------------------------------------------------
   dms_debounce #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_btn (
      .core_clk(core_clk),
      .srst(srst),
      .btn_raw(select_btn),
      .short_press(short_press),
      .long_press(long_press)
   );

   // ----------------------------------------------------------------------
   // View and sequence control
   // ----------------------------------------------------------------------
   // Presses during a pending switch are dropped: the operator sees no
   // change yet, and queuing them would make the panel run ahead.
   always @(posedge core_clk) begin
      if (srst) begin
         view <= `DMS_V_LOCAL;
         pend_view <= `DMS_V_LOCAL;
         switching <= 1'b0;
         sw_cnt <= 32'h0000_0000;
         sub <= `DMS_S_TEMP;
         phase <= `DMS_PH_ZERO;
         board <= {BW{1'b0}};
         far_tag_done <= 1'b0;
         dwell_cnt <= 32'h0000_0000;
         blinking <= 1'b0;
      end else if (switching) begin
         // Longer wait when the target is the diagnostic view
         if (sw_cnt >= ((pend_view == `DMS_V_DIAGNOSTIC_VIEW) ? DIAGNOSTIC_VIEW_DELAY_CYC : VIEW_DELAY_CYC) - 1) begin
            switching <= 1'b0;
            view <= pend_view;
            sub <= `DMS_S_TEMP;
            blinking <= (pend_view == `DMS_V_DIAGNOSTIC_VIEW);
            phase <= `DMS_PH_ZERO;
            board <= {BW{1'b0}};
            far_tag_done <= 1'b0;
            dwell_cnt <= 32'h0000_0000;
         end else begin
            sw_cnt <= sw_cnt + 32'h0000_0001;
         end
      end else if (any_press && !(in_diagnostic_view && short_press)) begin
         // Any press outside diagnostics, or a held press inside it
         switching <= 1'b1;
         pend_view <= next_view;
         sw_cnt <= 32'h0000_0000;
      end else if (in_diagnostic_view && short_press) begin
         // Quick press steps the diagnostic sub-view cyclically
         sub <= {sub[2:0], sub[3]};
         phase <= `DMS_PH_ZERO;
         board <= {BW{1'b0}};
         dwell_cnt <= 32'h0000_0000;
      end else if (fw_skip) begin
         // Boards without a controller have no version to show
         board <= next_board(board);
         phase <= `DMS_PH_ZERO;
      end else if (dwell_tick) begin
         dwell_cnt <= 32'h0000_0000;
         blinking <= 1'b0;
         // Sequences run forever until the next press
         case (view)
            `DMS_V_LOCAL: begin
               phase <= {1'b0, ~phase[0]};
            end
            `DMS_V_REMOTE: begin
               if (!far_tag_done) begin
                  far_tag_done <= 1'b1;
                  phase <= `DMS_PH_ZERO;
               end else begin
                  phase <= {1'b0, ~phase[0]};
               end
            end
            `DMS_V_DIAGNOSTIC_VIEW: begin
               case (sub)
                  `DMS_S_TEMP, `DMS_S_SUPPLY: begin
                     if (phase == `DMS_PH_LAST4) begin
                        // Label opens the sub-view once; each next board
                        // then runs tag, label, value
                        phase <= `DMS_PH_ONE;
                        board <= next_board(board);
                     end else begin
                        phase <= phase + 2'h1;
                     end
                  end
                  `DMS_S_FW: begin
                     if (phase == `DMS_PH_TWO) begin
                        phase <= `DMS_PH_ZERO;
                        board <= next_board(board);
                     end else begin
                        phase <= phase + 2'h1;
                     end
                  end
                  default: begin
                     phase <= {1'b0, ~phase[0]};
                  end
               endcase
            end
            default: begin
               phase <= `DMS_PH_ZERO;
            end
         endcase
      end else begin
         dwell_cnt <= dwell_cnt + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------------
   // Blink divider for the diagnostic LED
   // ----------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst || !blinking) begin
         blink_cnt <= 32'h0000_0000;
         blink_on <= 1'b0;
      end else if (blink_cnt >= BLINK_CYC - 1) begin
         blink_cnt <= 32'h0000_0000;
         blink_on <= ~blink_on;
      end else begin
         blink_cnt <= blink_cnt + 32'h0000_0001;
      end
   end

   // View LEDs: apart from the far tag on remote entry, the only way to tell the two receive views apart
   assign led_local = (view == `DMS_V_LOCAL);
   assign led_remote = (view == `DMS_V_REMOTE);
   assign led_diagnostic_view = in_diagnostic_view && !(blinking && !blink_on);

   // ----------------------------------------------------------------------
   // Text and colour
   // ----------------------------------------------------------------------
   reg [31:0] next_text; // Text for the current item
   reg next_red; // Item shown red
   wire [7:0] temp_sel = board_temp_c[board*8 +: 8];
   wire [15:0] fw_sel = board_fw_version[board*16 +: 16];
   wire [31:0] tag_sel = BOARD_TAGS[board*32 +: 32];

   always @* begin
      next_text = `DMS_TXT_LINK;
      next_red = 1'b0;
      case (view)
         `DMS_V_LOCAL: begin
            next_text = phase[0] ? `DMS_TXT_LINK : fmt_num(local_rx_dbm, 1'b0);
         end
         `DMS_V_REMOTE: begin
            if (!far_tag_done) begin
               next_text = `DMS_TXT_FAR;
            end else begin
               next_text = phase[0] ? `DMS_TXT_LINK : fmt_num(remote_rx_dbm, 1'b0);
            end
         end
         `DMS_V_DIAGNOSTIC_VIEW: begin
            case (sub)
               `DMS_S_TEMP: begin
                  next_red = !(&board_temp_ok);
                  case (phase)
                     `DMS_PH_ONE: next_text = tag_sel;
                     `DMS_PH_LAST4: next_text = fmt_num(temp_sel, 1'b1);
                     default: next_text = `DMS_TXT_TEMP;
                  endcase
               end
               `DMS_S_SUPPLY: begin
                  next_red = !(&board_supply_ok);
                  case (phase)
                     `DMS_PH_ONE: next_text = tag_sel;
                     `DMS_PH_LAST4: begin
                        next_text = board_supply_ok[board] ? `DMS_TXT_OK : `DMS_TXT_FAIL;
                     end
                     default: next_text = `DMS_TXT_SUPPLY;
                  endcase
               end
               `DMS_S_FW: begin
                  case (phase)
                     `DMS_PH_ONE: next_text = tag_sel;
                     `DMS_PH_TWO: begin
                        next_text = {dig(fw_sel[15:12]), dig(fw_sel[11:8]),
                                     dig(fw_sel[7:4]), dig(fw_sel[3:0])};
                     end
                     default: next_text = `DMS_TXT_FW;
                  endcase
               end
               default: begin
                  next_red = (far_error != 16'h0000);
                  next_text = phase[0] ? {dig(far_error[15:12]), dig(far_error[11:8]),
                                          dig(far_error[7:4]), dig(far_error[3:0])}
                                       : `DMS_TXT_ERR;
               end
            endcase
         end
         default: begin
            next_text = `DMS_TXT_LINK;
         end
      endcase
   end

   // Display outputs are registered, one cycle after the item changes
   always @(posedge core_clk) begin
      if (srst) begin
         disp_text <= `DMS_TXT_LINK;
         disp_green <= 1'b0;
         disp_red <= 1'b0;
      end else begin
         disp_text <= next_text;
         disp_green <= !next_red;
         disp_red <= next_red;
      end
   end

endmodule // dms_display_mode_sequencer

// ==== dms_seq_checker_asserts.sv ====
// Port checker for the display mode sequencer, bound to its top module
`timescale 1ns/1ps
`include "dms_map.vh"

module dms_seq_checker #(
   parameter NUM_BOARDS = 4
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Watched status inputs
   input wire [NUM_BOARDS-1:0] board_temp_ok,
   input wire [15:0] far_error,
   // Display and LEDs
   input wire [31:0] disp_text,
   input wire disp_green,
   input wire disp_red,
   input wire led_local,
   input wire led_remote,
   input wire led_diagnostic_view
);
   // ---------------------------------------------
   // One clock domain, reset disables all checks
   // ---------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_one_led; $onehot0({led_local, led_remote, led_diagnostic_view}); endproperty
   a_one_led: assert property (p_one_led) else $error("two view leds lit");
   property p_colour; !$past(srst) |-> (disp_green ^ disp_red); endproperty
   a_colour: assert property (p_colour) else $error("colour not exclusive");
   // Dwell: a local item stands seven more cycles unless the view leaves
   property p_dwell;
      (led_local && $changed(disp_text)) |=> (!led_local || $stable(disp_text))[*7];
   endproperty
   a_dwell: assert property (p_dwell) else $error("local item too short");
   property p_alt;
      (led_local && $past(led_local, 2) && $changed(disp_text)) |->
         ((disp_text == `DMS_TXT_LINK) != ($past(disp_text) == `DMS_TXT_LINK));
   endproperty
   a_alt: assert property (p_alt) else $error("local items not alternating");
   property p_far_first; $rose(led_remote) |=> (disp_text == `DMS_TXT_FAR); endproperty
   a_far_first: assert property (p_far_first) else $error("remote not opened by tag");
   property p_far_once;
      (led_remote && $past(led_remote, 2) && $changed(disp_text)) |-> (disp_text != `DMS_TXT_FAR);
   endproperty
   a_far_once: assert property (p_far_once) else $error("remote tag repeated");
   property p_ord_local; $fell(led_local) |-> led_remote; endproperty
   a_ord_local: assert property (p_ord_local) else $error("local not followed by remote");
   // Diagnostic entry opens on temperature with the led dark
   property p_diagnostic_view_in;
      $fell(led_remote) |-> !led_local ##1 (disp_text == `DMS_TXT_TEMP && !led_diagnostic_view);
   endproperty
   a_diagnostic_view_in: assert property (p_diagnostic_view_in) else $error("bad diagnostic entry");
   property p_err_col;
      (disp_text == `DMS_TXT_ERR && $stable(far_error)) |-> (disp_red == (far_error != 16'h0000));
   endproperty
   a_err_col: assert property (p_err_col) else $error("error view colour wrong");
   // Temperature label is red whenever any board runs out of range
   property p_temp_col;
      (disp_text == `DMS_TXT_TEMP && $stable(board_temp_ok)) |->
         (disp_red == !(&board_temp_ok));
   endproperty
   a_temp_col: assert property (p_temp_col) else $error("temperature colour wrong");

   // Main scenarios reached
   c_remote: cover property ($rose(led_remote));
   c_diagnostic_view: cover property ($fell(led_remote));
   c_red: cover property ($rose(disp_red));
endmodule // dms_seq_checker

bind dms_display_mode_sequencer dms_seq_checker #(.NUM_BOARDS(NUM_BOARDS)) u_chk (
   .core_clk(core_clk), .srst(srst), .board_temp_ok(board_temp_ok), .far_error(far_error),
   .disp_text(disp_text), .disp_green(disp_green), .disp_red(disp_red),
   .led_local(led_local), .led_remote(led_remote), .led_diagnostic_view(led_diagnostic_view));

// ==== dms_panel_model.sv ====
// Operator button model: bouncy press of a commanded length
`timescale 1ns/1ps

module dms_panel_model (
   // Clock
   input wire core_clk,
   // Command from the bench
   input wire press_go,
   input wire [7:0] hold_cyc,
   // Button line, high while pressed
   output reg select_btn,
   output reg busy
);
   // ---------------------------------------------
   // Contacts chatter one cycle at a time, shorter than debounce
   // ---------------------------------------------
   initial begin
      select_btn = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge core_clk);
         if (press_go) begin
            busy <= 1'b1;
            select_btn <= 1'b1;
            @(posedge core_clk) select_btn <= 1'b0;
            @(posedge core_clk) select_btn <= 1'b1;
            // Zero hold gives chatter only, no real press
            if (hold_cyc == 8'h00) begin
               @(posedge core_clk) select_btn <= 1'b0;
            end else begin
               repeat (hold_cyc) @(posedge core_clk);
               select_btn <= 1'b0;
               @(posedge core_clk) select_btn <= 1'b1;
               @(posedge core_clk) select_btn <= 1'b0;
            end
            repeat (10) @(posedge core_clk);
            busy <= 1'b0;
         end
      end
   end
endmodule // dms_panel_model

// ==== dms_display_mode_sequencer_tb.sv ====
// Self-checking bench for the display mode sequencer
`timescale 1ns/1ps
`include "dms_map.vh"

module dms_display_mode_sequencer_tb;
   // ---------------------------------------------
   // Expected texts
   // ---------------------------------------------
   localparam [31:0] LOC = 32'h202D_3133;
   localparam [31:0] L100 = 32'h2D31_3030;
   localparam [31:0] REM = 32'h2020_2D39;
   localparam [31:0] T_PS = 32'h5053_2020;
   localparam [31:0] T_BASE = 32'h4241_5345;
   localparam [31:0] T_DISP = 32'h4449_5350;
   localparam [31:0] DEG = 32'h2033_3743;
   localparam [31:0] VER = 32'h3141_3242;
   localparam [31:0] CODE = 32'h3030_4335;
   reg core_clk, srst, press_go;
   reg [7:0] hold_cyc, local_rx_dbm, remote_rx_dbm;
   reg [31:0] board_temp_c;
   reg [3:0] board_temp_ok, board_supply_ok, board_has_mcu;
   reg [63:0] board_fw_version;
   reg [15:0] far_error;
   wire select_btn, busy, disp_green, disp_red, led_local, led_remote, led_diagnostic_view;
   wire [31:0] disp_text;
   integer fail_count, tests_run, cyc;

   // Short counts keep the run brief
   dms_display_mode_sequencer #(.DEBOUNCE_CYC(4), .LONG_CYC(40), .DWELL_CYC(8),
      .VIEW_DELAY_CYC(5), .DIAGNOSTIC_VIEW_DELAY_CYC(12), .BLINK_CYC(2)) DUT (
      .core_clk(core_clk), .srst(srst), .select_btn(select_btn),
      .local_rx_dbm(local_rx_dbm), .remote_rx_dbm(remote_rx_dbm),
      .board_temp_c(board_temp_c), .board_temp_ok(board_temp_ok),
      .board_supply_ok(board_supply_ok), .board_has_mcu(board_has_mcu),
      .board_fw_version(board_fw_version), .far_error(far_error),
      .disp_text(disp_text), .disp_green(disp_green), .disp_red(disp_red),
      .led_local(led_local), .led_remote(led_remote), .led_diagnostic_view(led_diagnostic_view));
   dms_panel_model u_panel (.core_clk(core_clk), .press_go(press_go),
      .hold_cyc(hold_cyc), .select_btn(select_btn), .busy(busy));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         end_sim;
      end
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task check(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // Next item (seq) or first sighting of a text, bounded wait
   task see(input [8*8-1:0] what, input seq, input [31:0] exp);
      reg [31:0] old;
      integer n;
      begin
         n = 0;
         old = disp_text;
         while (n < 200 && (seq ? disp_text === old : disp_text !== exp)) begin
            @(negedge core_clk);
            n = n + 1;
         end
         check(what, exp, disp_text);
      end
   endtask
   task press(input [7:0] h);
      integer n;
      begin
         n = 0;
         while (busy !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n = n + 1;
         end
         hold_cyc = h;
         press_go = 1'b1;
         @(negedge core_clk);
         press_go = 1'b0;
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_local;
      begin
         see("loc", 0, LOC);
         check("ledl", 1, led_local);
         see("tag", 1, `DMS_TXT_LINK);
         see("loc", 1, LOC);
         press(8'h00);
         repeat (60) @(negedge core_clk);
         check("ledl", 1, led_local);
         $display("done local");
      end
   endtask
   task t_remote;
      begin
         press(8'd10);
         see("far", 0, `DMS_TXT_FAR);
         check("leds", 3'b010, {led_local, led_remote, led_diagnostic_view});
         see("rem", 1, REM);
         see("tag", 1, `DMS_TXT_LINK);
         see("rem", 1, REM);
         $display("done remote");
      end
   endtask
   task t_diagnostic_view;
      begin
         press(8'd10);
         see("temp", 0, `DMS_TXT_TEMP);
         check("leds", 2'b00, {led_local, led_remote});
         check("green", 1, disp_green);
         see("tag", 1, T_PS);
         see("temp", 1, `DMS_TXT_TEMP);
         see("deg", 1, DEG);
         see("tag", 1, T_BASE);
         $display("done diagnostic_view");
      end
   endtask
   task t_subs;
      begin
         board_temp_ok = 4'b1110;
         press(8'd10);
         see("supply_health_submode", 0, `DMS_TXT_SUPPLY);
         check("red", 1, disp_red);
         see("tag", 1, T_PS);
         see("supply_health_submode", 1, `DMS_TXT_SUPPLY);
         see("ok", 1, `DMS_TXT_OK);
         see("tag", 1, T_BASE);
         see("supply_health_submode", 1, `DMS_TXT_SUPPLY);
         see("fail", 1, `DMS_TXT_FAIL);
         press(8'd10);
         see("rev", 0, `DMS_TXT_FW);
         see("tag", 1, T_DISP);
         see("ver", 1, VER);
         press(8'd10);
         see("cam", 0, `DMS_TXT_ERR);
         check("red", 1, disp_red);
         see("code", 1, CODE);
         see("cam", 1, `DMS_TXT_ERR);
         far_error = 16'h0000;
         see("code", 1, 32'h3030_3030);
         check("green", 1, disp_green);
         press(8'd10);
         see("temp", 0, `DMS_TXT_TEMP);
         check("red", 1, disp_red);
         local_rx_dbm = 8'h9C;
         press(8'd60);
         see("loc", 0, L100);
         check("ledl", 1, led_local);
         $display("done subviews");
      end
   endtask

   task end_sim;
      begin
         $display("checks %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      fail_count = 0;
      tests_run = 0;
      cyc = 0;
      srst = 1'b1;
      press_go = 1'b0;
      hold_cyc = 8'h00;
      local_rx_dbm = 8'hF3;
      remote_rx_dbm = 8'hF7;
      board_temp_c = 32'h0000_2F25;
      board_temp_ok = 4'hF;
      board_supply_ok = 4'b1101;
      board_has_mcu = 4'b0100;
      board_fw_version = 64'h0000_1A2B_0000_0000;
      far_error = 16'h00C5;
      repeat (8) @(negedge core_clk);
      srst = 1'b0;
      t_local;
      t_remote;
      t_diagnostic_view;
      t_subs;
      end_sim;
   end
endmodule // dms_display_mode_sequencer_tb
